// file: bcu_cfg.svh
`ifndef BCU_CFG_SVH
`define BCU_CFG_SVH

// Opcode patterns.
`define BCU_OP_PREFIX 8'h48
`define BCU_OP_WIDE_JUMP 8'h28
`define BCU_OP_PAIR_CALL 8'h29
`define BCU_OP_CALL 8'h40
`define BCU_SHORT_TOP 2'h3
`define BCU_LONG_TOP 7'h27
`define BCU_FIXED_TOP 5'h0f
`define BCU_FIXED_PAGE 5'h01

// Field positions.
`define BCU_SHORT_SIGN 5
`define BCU_LONG_SIGN 0

// Instruction lengths in bytes.
`define BCU_LEN_ONE 16'h0001
`define BCU_LEN_TWO 16'h0002
`define BCU_LEN_CALL 16'h0003

// Execution lengths in states (one state is one clock).
`define BCU_ST_SHORT 5'h0a
`define BCU_ST_LONG 5'h0a
`define BCU_ST_WIDE 5'h08
`define BCU_ST_CALL 5'h10
`define BCU_ST_PAIR 5'h11
`define BCU_ST_FIXED 5'h0d

// Reset values.
`define BCU_RST_PC 16'h0000
`define BCU_RST_SP 16'h0000

`endif

// file: bcu_pkg.sv
`default_nettype none
package bcu_pkg;

    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_SHORT = 3'b001,
        K_LONG = 3'b010,
        K_WIDE = 3'b011,
        K_CALL = 3'b100,
        K_PAIR = 3'b101,
        K_FIXED = 3'b110
    } kind_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CHECK = 3'b001,
        ST_PUSH_HI = 3'b010,
        ST_PUSH_LO = 3'b011,
        ST_WAIT = 3'b100
    } state_t;

endpackage

`default_nettype wire

// file: target_calc.sv
`timescale 1ns/100ps
`default_nettype none
`include "bcu_cfg.svh"

module target_calc (
    input wire logic [7:0] op0,
    input wire logic [7:0] op1,
    input wire logic [7:0] op2,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] wacc_in,
    input wire logic [7:0] b_in,
    input wire logic [7:0] c_in,
    output var bcu_pkg::kind_t kind,
    output logic [15:0] target,
    output logic [15:0] ret_addr,
    output logic [4:0] n_states
);
    import bcu_pkg::*;

    wire logic is_prefix;
    wire logic [15:0] len;
    wire logic [15:0] short_offset;
    wire logic [15:0] long_offset;
    wire logic long_sign;
    wire logic [10:0] fixed_area_target;

    assign is_prefix = (op0 == `BCU_OP_PREFIX);
    assign kind = (op0[7:6] == `BCU_SHORT_TOP) ? K_SHORT :
                  (op0[7:1] == `BCU_LONG_TOP) ? K_LONG :
                  (op0 == `BCU_OP_CALL) ? K_CALL :
                  (op0[7:3] == `BCU_FIXED_TOP) ? K_FIXED :
                  (is_prefix && op1 == `BCU_OP_WIDE_JUMP) ? K_WIDE :
                  (is_prefix && op1 == `BCU_OP_PAIR_CALL) ? K_PAIR : K_NONE;

    assign len = (kind == K_SHORT) ? `BCU_LEN_ONE :
                 (kind == K_CALL) ? `BCU_LEN_CALL : `BCU_LEN_TWO;
    // Return and relative base is the start of the next instruction.
    assign ret_addr = pc_in + len;

    assign short_offset = {{10{op0[`BCU_SHORT_SIGN]}}, op0[5:0]};
    assign long_sign = op0[`BCU_LONG_SIGN];
    assign long_offset = {{7{long_sign}}, long_sign, op1};
    assign fixed_area_target = {op0[2:0], op1};

    assign target = (kind == K_SHORT) ? ret_addr + short_offset :
                    (kind == K_LONG) ? ret_addr + long_offset :
                    (kind == K_WIDE) ? wacc_in :
                    (kind == K_CALL) ? {op2, op1} :
                    (kind == K_PAIR) ? {b_in, c_in} :
                    (kind == K_FIXED) ?
                        {`BCU_FIXED_PAGE, fixed_area_target} :
                    pc_in;

    assign n_states = (kind == K_SHORT) ? `BCU_ST_SHORT :
                      (kind == K_LONG) ? `BCU_ST_LONG :
                      (kind == K_WIDE) ? `BCU_ST_WIDE :
                      (kind == K_CALL) ? `BCU_ST_CALL :
                      (kind == K_PAIR) ? `BCU_ST_PAIR :
                      (kind == K_FIXED) ? `BCU_ST_FIXED : 5'h02;
endmodule

`default_nettype wire

// file: branch_call_unit.sv
// How it works
// - Short jump: next address plus signed 6-bit.
// - Long jump: next address plus signed 9-bit.
// - Long offset sign fills all upper bits.
// - Wide accumulator jump loads whole word, 8 states.
// - Calls push high at SP-1, low SP-2.
// - Direct call: bytes two, three; 16 states.
// - Pair call: B high, C low; 17 states.
// - Fixed call: page 00001 plus field; 13 states.
// - Completion clears omit and load-chain flags.
`timescale 1ns/100ps
`default_nettype none
`include "bcu_cfg.svh"

module branch_call_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] op0,
    input wire logic [7:0] op1,
    input wire logic [7:0] op2,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] sp_in,
    input wire logic [15:0] wacc_in,
    input wire logic [7:0] b_in,
    input wire logic [7:0] c_in,
    output logic busy_ff,
    output logic done_ff,
    output logic illegal_ff,
    output logic [15:0] pc_out_ff,
    output logic [15:0] sp_out_ff,
    output logic stack_we_ff,
    output logic [15:0] stack_addr_ff,
    output logic [7:0] stack_data_ff,
    output logic flag_wr_ff,
    output logic pending_omit_flag_ff,
    output logic load_chain_flag_one_ff,
    output logic load_chain_flag_zero_ff
);
    import bcu_pkg::*;

    state_t state_ff;
    state_t nxt_state;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic [7:0] op0_ff;
    logic [7:0] op1_ff;
    logic [7:0] op2_ff;
    logic [15:0] pc_ff;
    logic [15:0] sp_ff;
    logic [15:0] wacc_ff;
    logic [7:0] b_ff;
    logic [7:0] c_ff;

    kind_t kind;
    wire logic [15:0] target;
    wire logic [15:0] ret_addr;
    wire logic [4:0] n_states;
    wire logic accept, fin, bad;
    wire logic is_call;
    wire logic push_hi, push_lo;
    wire logic nxt_busy;
    wire logic [15:0] nxt_addr;
    wire logic [7:0] nxt_data;
    wire logic [15:0] nxt_sp;

    // Decoding works on the operands captured at start, so the caller may
    // change its inputs while the instruction runs.
    target_calc u_calc (
        .op0(op0_ff),
        .op1(op1_ff),
        .op2(op2_ff),
        .pc_in(pc_ff),
        .wacc_in(wacc_ff),
        .b_in(b_ff),
        .c_in(c_ff),
        .kind(kind),
        .target(target),
        .ret_addr(ret_addr),
        .n_states(n_states)
    );

    assign accept = start && !busy_ff;
    assign fin = (state_ff == ST_WAIT) && (cnt_ff == 5'h00);
    assign bad = (state_ff == ST_CHECK) && (kind == K_NONE);
    assign is_call = (kind == K_CALL) || (kind == K_PAIR) ||
                     (kind == K_FIXED);
    assign push_hi = (state_ff == ST_PUSH_HI);
    assign push_lo = (state_ff == ST_PUSH_LO);
    assign nxt_busy = accept || (busy_ff && !fin && !bad);
    assign nxt_addr = push_hi ? sp_ff - 16'h0001 : sp_ff - 16'h0002;
    assign nxt_data = push_hi ? ret_addr[15:8] : ret_addr[7:0];
    assign nxt_sp = is_call ? sp_ff - 16'h0002 : sp_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        if (state_ff != ST_IDLE && cnt_ff != 5'h00) begin
            nxt_cnt = cnt_ff - 5'h01;
        end
        case (state_ff)
            ST_IDLE: begin
                if (accept) begin
                    nxt_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // The capture cycle and this one are the first two states.
                nxt_cnt = n_states - 5'h02;
                if (kind == K_NONE) begin
                    nxt_state = ST_IDLE;
                end else if (is_call) begin
                    nxt_state = ST_PUSH_HI;
                end else begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_PUSH_HI: begin
                nxt_state = ST_PUSH_LO;
            end
            ST_PUSH_LO: begin
                nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (fin) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 5'h00;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            illegal_ff <= 1'b0;
            stack_we_ff <= 1'b0;
            stack_addr_ff <= 16'h0000;
            stack_data_ff <= 8'h00;
            flag_wr_ff <= 1'b0;
            pc_out_ff <= `BCU_RST_PC;
            sp_out_ff <= `BCU_RST_SP;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= fin;
            illegal_ff <= bad;
            stack_we_ff <= push_hi || push_lo;
            stack_addr_ff <= nxt_addr;
            stack_data_ff <= nxt_data;
            flag_wr_ff <= fin;
            if (fin) begin
                pc_out_ff <= target;
                sp_out_ff <= nxt_sp;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pending_omit_flag_ff <= 1'b0;
            load_chain_flag_one_ff <= 1'b0;
            load_chain_flag_zero_ff <= 1'b0;
        end else if (fin) begin
            pending_omit_flag_ff <= 1'b0;
            load_chain_flag_one_ff <= 1'b0;
            load_chain_flag_zero_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            op0_ff <= 8'h00;
            op1_ff <= 8'h00;
            op2_ff <= 8'h00;
            pc_ff <= 16'h0000;
            sp_ff <= 16'h0000;
            wacc_ff <= 16'h0000;
            b_ff <= 8'h00;
            c_ff <= 8'h00;
        end else if (accept) begin
            op0_ff <= op0;
            op1_ff <= op1;
            op2_ff <= op2;
            pc_ff <= pc_in;
            sp_ff <= sp_in;
            wacc_ff <= wacc_in;
            b_ff <= b_in;
            c_ff <= c_in;
        end
    end

    // Cycles since start, read only by the checks below.
    logic [4:0] run_cnt_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            run_cnt_ff <= 5'h00;
        end else if (accept) begin
            run_cnt_ff <= 5'h00;
        end else if (busy_ff) begin
            run_cnt_ff <= run_cnt_ff + 5'h01;
        end
    end

    property p_short_target;
        @(posedge clk) disable iff (rst)
        (done_ff && kind == K_SHORT) |-> pc_out_ff ==
            pc_ff + 16'h0001 + {{10{op0_ff[5]}}, op0_ff[5:0]};
    endproperty
    a_short_target: assert property (p_short_target)
        else $error("short jump target wrong");
    property p_long_target;
        @(posedge clk) disable iff (rst)
        (done_ff && kind == K_LONG) |-> pc_out_ff ==
            pc_ff + 16'h0002 + {{8{op0_ff[0]}}, op1_ff};
    endproperty
    a_long_target: assert property (p_long_target)
        else $error("long jump target wrong");
    property p_long_negative;
        @(posedge clk) disable iff (rst)
        (done_ff && kind == K_LONG && op0_ff[0]) |->
            (pc_ff + 16'h0002 - pc_out_ff) <= 16'h0100 &&
            (pc_ff + 16'h0002 - pc_out_ff) != 16'h0000;
    endproperty
    a_long_negative: assert property (p_long_negative)
        else $error("negative long offset not sign filled");
    property p_wide_jump;
        @(posedge clk) disable iff (rst)
        (done_ff && kind == K_WIDE) |->
            pc_out_ff == wacc_ff && run_cnt_ff == 5'h08;
    endproperty
    a_wide_jump: assert property (p_wide_jump)
        else $error("accumulator jump wrong target or length");
    property p_push_pair;
        @(posedge clk) disable iff (rst)
        $rose(stack_we_ff) |->
            stack_addr_ff == sp_ff - 16'h0001 &&
            stack_data_ff == ret_addr[15:8] ##1
            stack_we_ff && stack_addr_ff == sp_ff - 16'h0002 &&
            stack_data_ff == ret_addr[7:0] ##1 !stack_we_ff;
    endproperty
    a_push_pair: assert property (p_push_pair)
        else $error("return address push out of order");
    property p_call_sp;
        @(posedge clk) disable iff (rst)
        (done_ff && is_call) |-> sp_out_ff == sp_ff - 16'h0002;
    endproperty
    a_call_sp: assert property (p_call_sp)
        else $error("stack pointer not lowered by two");
    property p_call_direct;
        @(posedge clk) disable iff (rst)
        (done_ff && kind == K_CALL) |->
            pc_out_ff == {op2_ff, op1_ff} && run_cnt_ff == 5'h10 &&
            ret_addr == pc_ff + 16'h0003;
    endproperty
    a_call_direct: assert property (p_call_direct)
        else $error("direct call wrong");
    property p_call_pair;
        @(posedge clk) disable iff (rst)
        (done_ff && kind == K_PAIR) |->
            pc_out_ff == {b_ff, c_ff} && run_cnt_ff == 5'h11 &&
            ret_addr == pc_ff + 16'h0002;
    endproperty
    a_call_pair: assert property (p_call_pair)
        else $error("pair call wrong");
    property p_call_fixed;
        @(posedge clk) disable iff (rst)
        (done_ff && op0_ff[7:3] == 5'h0f) |->
            pc_out_ff == {5'h01, op0_ff[2:0], op1_ff} &&
            run_cnt_ff == 5'h0d;
    endproperty
    a_call_fixed: assert property (p_call_fixed)
        else $error("fixed area call wrong");
    property p_flags;
        @(posedge clk) disable iff (rst)
        $rose(busy_ff) ##1 !illegal_ff |-> ##[7:16] (done_ff &&
            flag_wr_ff && !pending_omit_flag_ff &&
            !load_chain_flag_one_ff && !load_chain_flag_zero_ff);
    endproperty
    a_flags: assert property (p_flags)
        else $error("flags not cleared on completion");

    c_short: cover property (@(posedge clk) done_ff && kind == K_SHORT);
    c_pair: cover property (@(posedge clk) done_ff && kind == K_PAIR);
    c_fixed: cover property (@(posedge clk) done_ff && kind == K_FIXED);
    c_bad: cover property (@(posedge clk) illegal_ff);
endmodule

`default_nettype wire

// file: tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk;
    logic rst;
    logic start;
    logic [7:0] op0, op1, op2, b_in, c_in;
    logic [15:0] pc_in, sp_in, wacc_in;
    logic busy_ff, done_ff, illegal_ff, stack_we_ff, flag_wr_ff;
    logic pending_omit_flag_ff, load_chain_flag_one_ff;
    logic load_chain_flag_zero_ff;
    logic [15:0] pc_out_ff, sp_out_ff, stack_addr_ff;
    logic [7:0] stack_data_ff;
    int errors;
    int tests_run;
    int cycles;

    branch_call_unit dut (
        .clk(clk), .rst(rst), .start(start),
        .op0(op0), .op1(op1), .op2(op2),
        .pc_in(pc_in), .sp_in(sp_in), .wacc_in(wacc_in),
        .b_in(b_in), .c_in(c_in),
        .busy_ff(busy_ff), .done_ff(done_ff), .illegal_ff(illegal_ff),
        .pc_out_ff(pc_out_ff), .sp_out_ff(sp_out_ff),
        .stack_we_ff(stack_we_ff), .stack_addr_ff(stack_addr_ff),
        .stack_data_ff(stack_data_ff), .flag_wr_ff(flag_wr_ff),
        .pending_omit_flag_ff(pending_omit_flag_ff),
        .load_chain_flag_one_ff(load_chain_flag_one_ff),
        .load_chain_flag_zero_ff(load_chain_flag_zero_ff)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task print_verdict;
        if (errors == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp,
             input string msg);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Runs one instruction and watches every cycle until it completes.
    // With hold set, start stays high and the opcode changes while busy.
    task automatic exec(input logic [7:0] a, b, c,
                        input logic [15:0] pc, sp, exp_pc, ret,
                        input int n_exp, input bit call, hold);
        int n;
        int k;
        n = 0;
        k = 0;
        op0 <= a;
        op1 <= b;
        op2 <= c;
        pc_in <= pc;
        sp_in <= sp;
        start <= 1'b1;
        @(posedge clk);
        start <= hold;
        if (hold)
            op0 <= 8'h40;
        while (n < 40) begin
            @(posedge clk);
            n++;
            if (n == n_exp)
                start <= 1'b0;
            #1;
            if (stack_we_ff === 1'b1) begin
                chk(16'(n), 16'(k + 2), "push cycle");
                chk(stack_addr_ff, sp - 16'h0001 - 16'(k),
                    "push addr");
                chk({8'h00, stack_data_ff},
                    {8'h00, k ? ret[7:0] : ret[15:8]},
                    "push data");
                k++;
            end
            if (done_ff === 1'b1)
                break;
        end
        chk(16'(n), 16'(n_exp), "states");
        chk(pc_out_ff, exp_pc, "new pc");
        chk(sp_out_ff, call ? sp - 16'h0002 : sp, "new sp");
        chk(16'(k), call ? 16'h0002 : 16'h0000, "push count");
        chk({12'h000, flag_wr_ff, pending_omit_flag_ff,
             load_chain_flag_one_ff, load_chain_flag_zero_ff},
            16'h0008, "flags");
        chk({15'h0000, busy_ff}, 16'h0000, "busy at done");
        @(posedge clk);
    endtask

    task t_reset;
        @(posedge clk);
        #1;
        chk({11'h000, busy_ff, done_ff, illegal_ff, stack_we_ff,
             flag_wr_ff}, 16'h0000, "reset strobes");
        chk(pc_out_ff, 16'h0000, "reset pc");
        chk(sp_out_ff, 16'h0000, "reset sp");
        @(posedge clk);
    endtask

    task t_short;
        logic [15:0] pc;
        logic [7:0] a;
        for (int i = 0; i < 2; i++) begin
            a = i ? 8'hdf : 8'he0;
            pc = i ? 16'hfff0 : 16'h0010;
            exec(a, 8'h00, 8'h00, pc, 16'h1000,
                 i ? 16'h0010 : 16'hfff1, 16'h0000,
                 10, 1'b0, 1'b0);
        end
    endtask

    task t_long;
        logic [7:0] a;
        logic [7:0] b;
        logic [15:0] e;
        for (int i = 0; i < 4; i++) begin
            a = i[0] ? 8'h4f : 8'h4e;
            b = i[1] ? 8'hff : 8'h00;
            e = i[1] ? (i[0] ? 16'h1001 : 16'h1101) :
                       (i[0] ? 16'h0f02 : 16'h1002);
            exec(a, b, 8'h00, 16'h1000, 16'h1000, e, 16'h0000,
                 10, 1'b0, 1'b0);
        end
    endtask

    task t_wide;
        wacc_in <= 16'hbeef;
        exec(8'h48, 8'h28, 8'h00, 16'h0400, 16'h1000, 16'hbeef, 16'h0000,
             8, 1'b0, 1'b0);
    endtask

    task t_call;
        exec(8'h40, 8'h34, 8'h12, 16'h2000, 16'h1000, 16'h1234, 16'h2003,
             16, 1'b1, 1'b0);
        exec(8'h40, 8'hff, 8'h00, 16'h12fe, 16'h0001, 16'h00ff, 16'h1301,
             16, 1'b1, 1'b0);
    endtask

    task t_pair;
        b_in <= 8'hab;
        c_in <= 8'hcd;
        exec(8'h48, 8'h29, 8'h00, 16'h3ffe, 16'h8000, 16'habcd, 16'h4000,
             17, 1'b1, 1'b0);
    endtask

    task t_fixed;
        logic [7:0] a;
        for (int i = 0; i < 2; i++) begin
            a = i ? 8'h7f : 8'h78;
            exec(a, 8'h5a, 8'h00, 16'h01ff, 16'h2000,
                 {5'h01, a[2:0], 8'h5a}, 16'h0201,
                 13, 1'b1, 1'b0);
        end
    endtask

    // A second request and a changed opcode while busy must be ignored.
    task t_busy;
        exec(8'hc3, 8'h00, 8'h00, 16'h0500, 16'h1000, 16'h0504, 16'h0000,
             10, 1'b0, 1'b1);
    endtask

    task t_illegal;
        for (int i = 0; i < 2; i++) begin
            op0 <= i ? 8'h48 : 8'h00;
            op1 <= 8'h00;
            start <= 1'b1;
            @(posedge clk);
            start <= 1'b0;
            @(posedge clk);
            #1;
            chk({13'h0000, illegal_ff, done_ff, busy_ff},
                16'h0004, "illegal");
            @(posedge clk);
            #1;
            chk({13'h0000, illegal_ff, done_ff, stack_we_ff},
                16'h0000, "after");
            @(posedge clk);
        end
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles >= 2000) begin
            errors++;
            print_verdict();
        end
    end

    initial begin
        rst = 1'b1;
        start = 1'b0;
        op0 = 8'h00;
        op1 = 8'h00;
        op2 = 8'h00;
        pc_in = 16'h0000;
        sp_in = 16'h0000;
        wacc_in = 16'h0000;
        b_in = 8'h00;
        c_in = 8'h00;
        errors = 0;
        tests_run = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_short();
        t_long();
        t_wide();
        t_call();
        t_pair();
        t_fixed();
        t_busy();
        t_illegal();
        print_verdict();
    end
endmodule
`default_nettype wire
